// ### camera_model.sv
`timescale 1ns/1ps
module camera_model (
    input wire logic link_clk,
    output logic hdr_valid = 1'b0,
    output logic [7:0] hdr_id = 8'h00,
    output logic hdr_ecc_fail = 1'b0,
    output logic pkt_end = 1'b0,
    output logic pkt_crc_fail = 1'b0,
    output logic payload_valid = 1'b0,
    output logic [7:0] payload_byte = 8'h00
);
    task automatic step();
        @(posedge link_clk);
        #2;
    endtask : step
    // Qualifiers flip once their strobe drops (payload_byte only after the last byte, not in gaps), so stale values cannot pass
    task automatic send(input logic [7:0] id, input logic ecc, input int n, input logic crc, input int gap);
        step();
        hdr_valid = 1'b1;
        hdr_id = id;
        hdr_ecc_fail = ecc;
        step();
        hdr_valid = 1'b0;
        hdr_id = ~id;
        hdr_ecc_fail = ~ecc;
        for (int k = 0; k < n; k++) begin
            payload_valid = 1'b1;
            payload_byte = 8'hA0 + 8'(k);
            step();
            if (gap > 0) begin
                payload_valid = 1'b0;
                repeat (gap) step();
            end
        end
        payload_valid = 1'b0;
        payload_byte = ~payload_byte;
        pkt_end = (n > 0);
        pkt_crc_fail = crc;
        step();
        pkt_end = 1'b0;
        pkt_crc_fail = ~crc;
    endtask : send
endmodule : camera_model

// ### cdc_word.sv
`timescale 1ns/1ps

module cdc_word #(
    parameter int WIDTH = 8
) (
    input wire logic src_clk,
    input wire logic src_rst_b,
    input wire logic src_valid,
    input wire logic [WIDTH-1:0] src_data,
    output logic src_busy,
    input wire logic dst_clk,
    input wire logic dst_rst_b,
    output logic dst_strobe,
    output logic [WIDTH-1:0] dst_data
);

    logic req, next_req;
    logic [WIDTH-1:0] hold, next_hold;
    logic ack_meta, ack_sync;
    logic req_meta, req_sync, req_last;
    logic [WIDTH-1:0] data_r, next_data_r;
    logic strobe_r, next_strobe_r;
    logic req_new;

    // Hold only changes once the far side has acknowledged, so it is stable whenever sampled
    assign src_busy = req ^ ack_sync;

    always_comb begin
        next_req = req;
        next_hold = hold;
        if (src_valid && !src_busy) begin
            next_req = ~req;
            next_hold = src_data;
        end
    end

    always_ff @(posedge src_clk) begin
        if (!src_rst_b) begin
            req <= 1'b0;
            hold <= '0;
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
        end else begin
            req <= next_req;
            hold <= next_hold;
            ack_meta <= req_last;
            ack_sync <= ack_meta;
        end
    end

    assign req_new = req_sync ^ req_last;

    always_comb begin
        next_strobe_r = req_new;
        next_data_r = req_new ? hold : data_r;
    end

    always_ff @(posedge dst_clk) begin
        if (!dst_rst_b) begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
            req_last <= 1'b0;
            data_r <= '0;
            strobe_r <= 1'b0;
        end else begin
            req_meta <= req;
            req_sync <= req_meta;
            req_last <= req_sync;
            data_r <= next_data_r;
            strobe_r <= next_strobe_r;
        end
    end

    assign dst_strobe = strobe_r;
    assign dst_data = data_r;

endmodule : cdc_word

// ### csi_header_select_status.sv
`timescale 1ns/1ps
`include "csi_regs.svh"

module csi_header_select_status
    import csi_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic link_clk,
    input wire logic hdr_valid,
    input wire logic [7:0] hdr_id,
    input wire logic hdr_ecc_fail,
    input wire logic pkt_end,
    input wire logic pkt_crc_fail,
    input wire logic payload_valid,
    input wire logic [7:0] payload_byte,
    output logic pix_valid,
    output logic [7:0] pix_byte,
    output logic [3:0] pix_width,
    output logic pix_embedded,
    output logic [5:0] pix_type,
    output logic packet_irq,
    output logic fault_out
);

    logic scl_meta, scl_sync, scl_last;
    logic sda_meta, sda_sync, sda_last;
    logic scl_rise, scl_fall, bus_start, bus_stop;

    i2c_state_t state, next_state;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shift, next_shift;
    logic [7:0] ptr, next_ptr;
    logic rw, next_rw;
    logic nack, next_nack;
    logic sda_oe_r, next_sda_oe;
    logic wr_en, next_wr_en;
    logic [7:0] wr_addr, next_wr_addr;
    logic [7:0] wr_data, next_wr_data;
    logic [7:0] rd_data;

    logic [1:0] fault, next_fault;
    logic pkt_flag, next_pkt_flag;
    logic [7:0] rx_id, next_rx_id;
    logic [7:0] image_id, next_image_id;
    logic [7:0] emb_id, next_emb_id;
    logic [3:0] sel, next_sel;
    logic [3:0] width_ovr, next_width_ovr;
    logic clr_pkt, clr_fault;

    config_word_t cfg_now, cfg_sent, next_cfg_sent, cfg_link;
    logic cfg_pending, cfg_busy, cfg_link_strobe;
    event_word_t ev_link, ev_word;
    logic ev_link_valid, ev_link_busy, ev_strobe;
    logic link_rst_b;

    // Control port pins come from outside; the extra stage only feeds edge detection
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_last <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            sda_last <= 1'b1;
        end else begin
            scl_meta <= scl;
            scl_sync <= scl_meta;
            scl_last <= scl_sync;
            sda_meta <= sda_in;
            sda_sync <= sda_meta;
            sda_last <= sda_sync;
        end
    end

    assign scl_rise = scl_sync && !scl_last;
    assign scl_fall = !scl_sync && scl_last;
    assign bus_start = scl_sync && scl_last && sda_last && !sda_sync;
    assign bus_stop = scl_sync && scl_last && !sda_last && sda_sync;

    // Open-drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_r;

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        next_ptr = ptr;
        next_rw = rw;
        next_nack = nack;
        next_sda_oe = sda_oe_r;
        next_wr_en = 1'b0;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        if (bus_stop) begin
            next_state = st_idle;
            next_sda_oe = 1'b0;
        end else if (bus_start) begin
            next_state = st_addr;
            next_bit_cnt = 4'h0;
            next_sda_oe = 1'b0;
        end else if (scl_rise) begin
            unique case (state)
                st_addr, st_reg, st_wdata: begin
                    next_shift = {shift[6:0], sda_sync};
                    next_bit_cnt = bit_cnt + 4'h1;
                end
                st_rdata: begin
                    next_bit_cnt = bit_cnt + 4'h1;
                end
                st_rack: begin
                    next_nack = sda_sync;
                end
                st_idle, st_ack_addr, st_ack_reg, st_ack_w: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (state)
                st_addr: begin
                    if (bit_cnt == 4'h8) begin
                        if (shift[7:1] == `I2C_DEV_ADDR) begin
                            next_state = st_ack_addr;
                            next_rw = shift[0];
                            next_sda_oe = 1'b1;
                        end else begin
                            next_state = st_idle;
                        end
                    end
                end
                st_ack_addr: begin
                    next_bit_cnt = 4'h0;
                    if (rw) begin
                        next_state = st_rdata;
                        next_shift = rd_data;
                        next_sda_oe = ~rd_data[7];
                    end else begin
                        next_state = st_reg;
                        next_sda_oe = 1'b0;
                    end
                end
                st_reg: begin
                    if (bit_cnt == 4'h8) begin
                        next_state = st_ack_reg;
                        next_ptr = shift;
                        next_sda_oe = 1'b1;
                    end
                end
                st_ack_reg, st_ack_w: begin
                    next_state = st_wdata;
                    next_bit_cnt = 4'h0;
                    next_sda_oe = 1'b0;
                    if (state == st_ack_w) begin
                        next_ptr = ptr + 8'h01;
                    end
                end
                st_wdata: begin
                    if (bit_cnt == 4'h8) begin
                        next_state = st_ack_w;
                        next_sda_oe = 1'b1;
                        next_wr_en = 1'b1;
                        next_wr_addr = ptr;
                        next_wr_data = shift;
                    end
                end
                st_rdata: begin
                    if (bit_cnt == 4'h8) begin
                        next_state = st_rack;
                        next_sda_oe = 1'b0;
                        next_ptr = ptr + 8'h01;
                    end else begin
                        next_shift = {shift[6:0], 1'b0};
                        next_sda_oe = ~shift[6];
                    end
                end
                st_rack: begin
                    next_bit_cnt = 4'h0;
                    if (nack) begin
                        next_state = st_idle;
                    end else begin
                        next_state = st_rdata;
                        next_shift = rd_data;
                        next_sda_oe = ~rd_data[7];
                    end
                end
                st_idle: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state <= st_idle;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            ptr <= 8'h00;
            rw <= 1'b0;
            nack <= 1'b0;
            sda_oe_r <= 1'b0;
            wr_en <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            ptr <= next_ptr;
            rw <= next_rw;
            nack <= next_nack;
            sda_oe_r <= next_sda_oe;
            wr_en <= next_wr_en;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
        end
    end

    // Clear bits are not stored, so the register always reads back as zero
    always_comb begin
        unique case (ptr)
            `FAULT_STATUS_OFS: rd_data = {6'h00, fault};
            `RECEIVED_ID_OFS: rd_data = rx_id;
            `EVENT_CLEAR_OFS: rd_data = 8'h00;
            `IMAGE_ID_OFS: rd_data = image_id;
            `EMBEDDED_ID_OFS: rd_data = emb_id;
            `STREAM_SEL_OFS: rd_data = {4'h0, sel};
            `WIDTH_OVERRIDE_OFS: rd_data = {4'h0, width_ovr};
            default: rd_data = 8'h00;
        endcase
    end

    assign clr_pkt = wr_en && (wr_addr == `EVENT_CLEAR_OFS) && wr_data[`CLR_PACKET_EVENT_BIT];
    assign clr_fault = wr_en && (wr_addr == `EVENT_CLEAR_OFS) && wr_data[`CLR_FAULT_BIT];

    always_comb begin
        next_image_id = image_id;
        next_emb_id = emb_id;
        next_sel = sel;
        next_width_ovr = width_ovr;
        next_rx_id = (ev_strobe && ev_word.id_valid) ? ev_word.id : rx_id;
        // An event landing in the clearing cycle survives the clear
        next_pkt_flag = (ev_strobe && ev_word.packet) || (pkt_flag && !clr_pkt);
        next_fault[`FAULT_CRC_BIT] = (ev_strobe && ev_word.crc_fail) ||
            (fault[`FAULT_CRC_BIT] && !clr_fault);
        next_fault[`FAULT_ECC_BIT] = (ev_strobe && ev_word.ecc_fail) ||
            (fault[`FAULT_ECC_BIT] && !clr_fault);
        if (wr_en) begin
            unique case (wr_addr)
                `IMAGE_ID_OFS: next_image_id = wr_data;
                `EMBEDDED_ID_OFS: next_emb_id = wr_data;
                `STREAM_SEL_OFS: next_sel = wr_data[3:0];
                `WIDTH_OVERRIDE_OFS: next_width_ovr = wr_data[3:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            fault <= 2'h0;
            pkt_flag <= 1'b0;
            rx_id <= `REG_RESET;
            image_id <= `REG_RESET;
            emb_id <= `REG_RESET;
            sel <= `SEL_RESET;
            width_ovr <= `WIDTH_RESET;
        end else begin
            fault <= next_fault;
            pkt_flag <= next_pkt_flag;
            rx_id <= next_rx_id;
            image_id <= next_image_id;
            emb_id <= next_emb_id;
            sel <= next_sel;
            width_ovr <= next_width_ovr;
        end
    end

    assign packet_irq = pkt_flag;
    assign fault_out = |fault;

    // Configuration is resent whenever it differs from the value last sent to the link side
    assign cfg_now = {sel, image_id, emb_id, width_ovr};
    assign cfg_pending = cfg_now != cfg_sent;

    always_comb begin
        next_cfg_sent = (cfg_pending && !cfg_busy) ? cfg_now : cfg_sent;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cfg_sent <= '0;
        end else begin
            cfg_sent <= next_cfg_sent;
        end
    end

    cdc_word #(.WIDTH($bits(config_word_t))) u_cfg_cross (
        .src_clk(mclk),
        .src_rst_b(rst_b),
        .src_valid(cfg_pending),
        .src_data(cfg_now),
        .src_busy(cfg_busy),
        .dst_clk(link_clk),
        .dst_rst_b(link_rst_b),
        .dst_strobe(cfg_link_strobe),
        .dst_data(cfg_link)
    );

    cdc_word #(.WIDTH($bits(event_word_t))) u_event_cross (
        .src_clk(link_clk),
        .src_rst_b(link_rst_b),
        .src_valid(ev_link_valid),
        .src_data(ev_link),
        .src_busy(ev_link_busy),
        .dst_clk(mclk),
        .dst_rst_b(rst_b),
        .dst_strobe(ev_strobe),
        .dst_data(ev_word)
    );

    csi_link_rx u_link (
        .link_clk(link_clk),
        .rst_b(rst_b),
        .link_rst_b(link_rst_b),
        .hdr_valid(hdr_valid),
        .hdr_id(hdr_id),
        .hdr_ecc_fail(hdr_ecc_fail),
        .pkt_end(pkt_end),
        .pkt_crc_fail(pkt_crc_fail),
        .payload_valid(payload_valid),
        .payload_byte(payload_byte),
        .halt_req(fault_out),
        .cfg_strobe(cfg_link_strobe),
        .cfg_word(cfg_link),
        .ev_valid(ev_link_valid),
        .ev_word(ev_link),
        .ev_busy(ev_link_busy),
        .pix_valid(pix_valid),
        .pix_byte(pix_byte),
        .pix_width(pix_width),
        .pix_embedded(pix_embedded),
        .pix_type(pix_type)
    );

endmodule : csi_header_select_status

// ### csi_header_select_status_monitor.sv
`timescale 1ns/1ps
module csi_header_select_status_monitor (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic scl,
    input wire logic sda_oe,
    input wire logic link_clk,
    input wire logic hdr_valid,
    input wire logic hdr_ecc_fail,
    input wire logic pkt_end,
    input wire logic payload_valid,
    input wire logic [7:0] payload_byte,
    input wire logic pix_valid,
    input wire logic [7:0] pix_byte,
    input wire logic packet_irq,
    input wire logic fault_out
);
    logic [4:0] age;
    logic [4:0] next_age;
    // Link pulses outlast an mclk period, so none slips past this counter
    always_comb begin
        next_age = (age == 5'h1F) ? age : age + 5'h01;
        if (!rst_b || hdr_valid || pkt_end)
            next_age = 5'h00;
    end
    always_ff @(posedge mclk) begin
        age <= next_age;
    end
    sequence halted_s;
        fault_out [*6];
    endsequence
    byte_pass_a: assert property (@(posedge link_clk) disable iff (!rst_b)
        pix_valid |-> $past(payload_valid) && pix_byte == $past(payload_byte)) else $error("byte mismatch");
    halt_hold_a: assert property (@(posedge link_clk) disable iff (!rst_b)
        halted_s |-> !pix_valid) else $error("stream not halted");
    ecc_flag_a: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(hdr_valid && hdr_ecc_fail) |-> ##[1:20] fault_out) else $error("ecc fault missed");
    reset_quiet_a: assert property (@(posedge mclk)
        !rst_b |=> !fault_out && !packet_irq && !sda_oe) else $error("reset values wrong");
    fault_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
        $fell(fault_out) |-> !scl) else $error("fault dropped outside a write");
    irq_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
        $fell(packet_irq) |-> !scl) else $error("event dropped outside a write");
    fault_cause_a: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(fault_out) |-> age < 5'h14) else $error("fault without link event");
    irq_cause_a: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(packet_irq) |-> age < 5'h14) else $error("event without header");
endmodule : csi_header_select_status_monitor
bind csi_header_select_status csi_header_select_status_monitor monitor (.*);

// ### csi_link_rx.sv
`timescale 1ns/1ps
`include "csi_regs.svh"

module csi_link_rx
    import csi_pkg::*;
(
    input wire logic link_clk,
    input wire logic rst_b,
    output logic link_rst_b,
    input wire logic hdr_valid,
    input wire logic [7:0] hdr_id,
    input wire logic hdr_ecc_fail,
    input wire logic pkt_end,
    input wire logic pkt_crc_fail,
    input wire logic payload_valid,
    input wire logic [7:0] payload_byte,
    input wire logic halt_req,
    input wire logic cfg_strobe,
    input wire config_word_t cfg_word,
    output logic ev_valid,
    output event_word_t ev_word,
    input wire logic ev_busy,
    output logic pix_valid,
    output logic [7:0] pix_byte,
    output logic [3:0] pix_width,
    output logic pix_embedded,
    output logic [5:0] pix_type
);

    logic rst_meta, rst_sync;
    logic halt_meta, halt_sync;
    config_word_t cfg, next_cfg;
    event_word_t pend, next_pend;
    logic in_pkt, next_in_pkt;
    logic cur_embedded, next_cur_embedded;
    logic [5:0] cur_type, next_cur_type;
    logic [3:0] cur_width, next_cur_width;
    logic pix_valid_r, next_pix_valid_r;
    logic [7:0] pix_byte_r, next_pix_byte_r;
    logic vc_match, hdr_long;
    logic [5:0] hdr_type;

    // Reset reaches this domain late by two link edges; nothing here acts on the link before that
    always_ff @(posedge link_clk) begin
        rst_meta <= rst_b;
        rst_sync <= rst_meta;
    end
    assign link_rst_b = rst_sync;

    always_ff @(posedge link_clk) begin
        if (!rst_sync) begin
            halt_meta <= 1'b0;
            halt_sync <= 1'b0;
        end else begin
            halt_meta <= halt_req;
            halt_sync <= halt_meta;
        end
    end

    assign vc_match = hdr_id[`ID_VC_MSB:`ID_VC_LSB] == cfg.select[1:0];
    assign hdr_long = hdr_id[`ID_DT_MSB:0] >= `SHORT_PKT_LIMIT;
    assign hdr_type = cfg.select[`SEL_TYPE_BIT] ? cfg.image_id[`ID_DT_MSB:0] : hdr_id[`ID_DT_MSB:0];
    assign ev_valid = pend.id_valid | pend.packet | pend.crc_fail | pend.ecc_fail;
    assign ev_word = pend;

    always_comb begin
        next_cfg = cfg_strobe ? cfg_word : cfg;
        next_pend = (ev_valid && !ev_busy) ? '0 : pend;
        next_in_pkt = in_pkt;
        next_cur_embedded = cur_embedded;
        next_cur_type = cur_type;
        next_cur_width = cur_width;
        if (pkt_end) begin
            next_in_pkt = 1'b0;
            if (pkt_crc_fail && in_pkt) begin
                next_pend.crc_fail = 1'b1;
            end
        end
        if (hdr_valid) begin
            next_pend.id = hdr_id;
            next_pend.id_valid = 1'b1;
            if (hdr_ecc_fail) begin
                next_pend.ecc_fail = 1'b1;
            end else if (vc_match && !hdr_long) begin
                next_pend.packet = 1'b1;
            end
            next_in_pkt = vc_match && hdr_long && !hdr_ecc_fail;
            next_cur_embedded = hdr_id == cfg.embedded_id;
            if (hdr_id == cfg.embedded_id) begin
                next_cur_type = hdr_id[`ID_DT_MSB:0];
                next_cur_width = width_of_type(hdr_id[`ID_DT_MSB:0]);
            end else begin
                next_cur_type = hdr_type;
                next_cur_width = cfg.select[`SEL_WIDTH_BIT] ? cfg.width : width_of_type(hdr_type);
            end
        end
        // A latched fault stops the outgoing stream until software clears it
        next_pix_valid_r = payload_valid && in_pkt && !halt_sync;
        next_pix_byte_r = payload_valid ? payload_byte : pix_byte_r;
    end

    always_ff @(posedge link_clk) begin
        if (!rst_sync) begin
            cfg <= '0;
            pend <= '0;
            in_pkt <= 1'b0;
            cur_embedded <= 1'b0;
            cur_type <= 6'h00;
            cur_width <= `WIDTH_DEFAULT;
            pix_valid_r <= 1'b0;
            pix_byte_r <= 8'h00;
        end else begin
            cfg <= next_cfg;
            pend <= next_pend;
            in_pkt <= next_in_pkt;
            cur_embedded <= next_cur_embedded;
            cur_type <= next_cur_type;
            cur_width <= next_cur_width;
            pix_valid_r <= next_pix_valid_r;
            pix_byte_r <= next_pix_byte_r;
        end
    end

    assign pix_valid = pix_valid_r;
    assign pix_byte = pix_byte_r;
    assign pix_width = cur_width;
    assign pix_embedded = cur_embedded;
    assign pix_type = cur_type;

endmodule : csi_link_rx

// ### csi_pkg.sv
`include "csi_regs.svh"

package csi_pkg;

    typedef enum logic [8:0] {
        st_idle = 9'h001,
        st_addr = 9'h002,
        st_ack_addr = 9'h004,
        st_reg = 9'h008,
        st_ack_reg = 9'h010,
        st_wdata = 9'h020,
        st_ack_w = 9'h040,
        st_rdata = 9'h080,
        st_rack = 9'h100
    } i2c_state_t;

    typedef struct packed {
        logic [7:0] id;
        logic id_valid;
        logic packet;
        logic crc_fail;
        logic ecc_fail;
    } event_word_t;

    typedef struct packed {
        logic [3:0] select;
        logic [7:0] image_id;
        logic [7:0] embedded_id;
        logic [3:0] width;
    } config_word_t;

    function automatic logic [3:0] width_of_type(input logic [5:0] dt);
        logic [3:0] w;
        w = `WIDTH_DEFAULT;
        case (dt)
            `DT_RAW6: w = 4'h6;
            `DT_RAW7: w = 4'h7;
            `DT_RAW8: w = 4'h8;
            `DT_RAW10: w = 4'hA;
            `DT_RAW12: w = 4'hC;
            default: w = `WIDTH_DEFAULT;
        endcase
        return w;
    endfunction : width_of_type

endpackage : csi_pkg

// ### csi_regs.svh
`ifndef CSI_REGS_SVH
`define CSI_REGS_SVH

// Register byte offsets on the control port
`define FAULT_STATUS_OFS 8'h10
`define RECEIVED_ID_OFS 8'h11
`define EVENT_CLEAR_OFS 8'h16
`define IMAGE_ID_OFS 8'h17
`define EMBEDDED_ID_OFS 8'h18
`define STREAM_SEL_OFS 8'h19
`define WIDTH_OVERRIDE_OFS 8'h1E

// Field positions
`define CLR_PACKET_EVENT_BIT 5
`define CLR_FAULT_BIT 4
`define FAULT_CRC_BIT 1
`define FAULT_ECC_BIT 0
`define SEL_WIDTH_BIT 3
`define SEL_TYPE_BIT 2
`define ID_VC_MSB 7
`define ID_VC_LSB 6
`define ID_DT_MSB 5

// Reset values
`define REG_RESET 8'h00
`define SEL_RESET 4'h0
`define WIDTH_RESET 4'h0

// Slave address on the control port, value is arbitrary
`define I2C_DEV_ADDR 7'h2A

// Data type codes; types below the limit are short packets
`define SHORT_PKT_LIMIT 6'h10
`define DT_RAW6 6'h28
`define DT_RAW7 6'h29
`define DT_RAW8 6'h2A
`define DT_RAW10 6'h2B
`define DT_RAW12 6'h2C
`define WIDTH_DEFAULT 4'h8

`endif

// ### test_csi_header_select_status.sv
`timescale 1ns/1ps
`include "csi_regs.svh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin fails++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module test_csi_header_select_status;
    logic mclk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_b = 1'b0;
    logic scl = 1'b1;
    logic sda_m = 1'b1;
    logic sda_out, sda_oe, hdr_valid, hdr_ecc_fail, pkt_end, pkt_crc_fail, payload_valid;
    logic pix_valid, pix_embedded, packet_irq, fault_out;
    logic [7:0] hdr_id, payload_byte, pix_byte;
    logic [8:0] r;
    logic [3:0] pix_width;
    logic [5:0] pix_type;
    int fails = 0;
    int comparisons = 0;
    int pix_count = 0;
    int seen;
    wire sda = sda_m & (sda_oe ? sda_out : 1'b1);
    csi_header_select_status dut (.*, .sda_in(sda));
    camera_model cam (.*);
    initial forever #12.5 mclk = ~mclk;
    initial begin
        #7;
        forever #24 link_clk = ~link_clk;
    end
    always @(posedge link_clk) if (pix_valid === 1'b1) pix_count++;
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask : tick
    task automatic bits(input logic [8:0] d);
        for (int i = 8; i >= 0; i--) begin
            sda_m = d[i];
            tick(6);
            scl = 1'b1;
            tick(8);
            r[i] = sda;
            scl = 1'b0;
            tick(2);
        end
    endtask : bits
    // Start when s is 1, stop when 0
    task automatic cond(input logic s);
        sda_m = s;
        tick(8);
        scl = 1'b1;
        tick(8);
        sda_m = !s;
        tick(8);
        scl = !s;
        tick(2);
    endtask : cond
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cond(1'b1);
        bits({`I2C_DEV_ADDR, 2'b01});
        bits({a, 1'b1});
        bits({d, 1'b1});
        `CHK("ack", 1'b0, r[0])
        cond(1'b0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        cond(1'b1);
        bits({`I2C_DEV_ADDR, 2'b01});
        bits({a, 1'b1});
        cond(1'b1);
        bits({`I2C_DEV_ADDR, 2'b11});
        bits(9'h1FF);
        `CHK("register", e, r[8:1])
        cond(1'b0);
    endtask : rd
    task automatic print_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (60000) @(posedge mclk);
        fails++;
        print_verdict();
    end
    initial begin
        tick(16);
        rst_b = 1'b1;
        tick(4);
        rd(`FAULT_STATUS_OFS, `REG_RESET);
        wr(`STREAM_SEL_OFS, 8'hF0);
        rd(`STREAM_SEL_OFS, `REG_RESET);
        rd(8'h20, 8'h00);
        $display("test registers done");
        seen = pix_count;
        cam.send({2'h0, `DT_RAW10}, 1'b0, 4, 1'b0, 0);
        `CHK("pix_count", seen + 4, pix_count)
        `CHK("pix_width", 4'hA, pix_width)
        `CHK("pix_type", `DT_RAW10, pix_type)
        cam.send({2'h1, `DT_RAW10}, 1'b0, 3, 1'b0, 2);
        `CHK("pix_count", seen + 4, pix_count)
        rd(`RECEIVED_ID_OFS, {2'h1, `DT_RAW10});
        $display("test stream done");
        wr(`IMAGE_ID_OFS, {2'h1, `DT_RAW12});
        wr(`WIDTH_OVERRIDE_OFS, 8'h05);
        wr(`EMBEDDED_ID_OFS, {2'h1, `DT_RAW6});
        wr(`STREAM_SEL_OFS, 8'h0D);
        rd(`WIDTH_OVERRIDE_OFS, 8'h05);
        cam.send({2'h1, `DT_RAW8}, 1'b0, 2, 1'b0, 0);
        `CHK("pix_type", `DT_RAW12, pix_type)
        `CHK("pix_width", 4'h5, pix_width)
        `CHK("pix_embedded", 1'b0, pix_embedded)
        cam.send({2'h1, `DT_RAW6}, 1'b0, 2, 1'b0, 0);
        `CHK("pix_embedded", 1'b1, pix_embedded)
        $display("test select done");
        cam.send({2'h1, `DT_RAW8}, 1'b1, 0, 1'b0, 0);
        rd(`FAULT_STATUS_OFS, 8'h01);
        seen = pix_count;
        cam.send({2'h1, `DT_RAW8}, 1'b0, 2, 1'b0, 0);
        `CHK("halted", seen, pix_count)
        wr(`EVENT_CLEAR_OFS, 8'h10);
        rd(`FAULT_STATUS_OFS, 8'h00);
        seen = pix_count;
        cam.send({2'h1, `DT_RAW8}, 1'b0, 2, 1'b1, 1);
        `CHK("pix_count", seen + 2, pix_count)
        rd(`FAULT_STATUS_OFS, 8'h02);
        wr(`EVENT_CLEAR_OFS, 8'h10);
        cam.send({2'h1, 6'h00}, 1'b0, 0, 1'b0, 0);
        tick(20);
        `CHK("packet_irq", 1'b1, packet_irq)
        wr(`EVENT_CLEAR_OFS, 8'h20);
        `CHK("packet_irq", 1'b0, packet_irq)
        rd(`EVENT_CLEAR_OFS, 8'h00);
        cam.send({2'h1, 6'h00}, 1'b0, 0, 1'b0, 0);
        tick(20);
        `CHK("packet_irq", 1'b1, packet_irq)
        $display("test events done");
        print_verdict();
    end
endmodule : test_csi_header_select_status
